// file: ubd_map.svh
`ifndef UBD_MAP_SVH
`define UBD_MAP_SVH
// Register indices; byte address is four times the index
`define UBD_IDX_DATA 10'h0C0
`define UBD_IDX_IEN 10'h0C1
`define UBD_IDX_IID 10'h0C2
`define UBD_IDX_LINE_CONTROL_REG 10'h0C3
`define UBD_IDX_LSTS 10'h0C5
`define UBD_DIV_RST 16'h0002
`define UBD_DIV_LO_RST 8'h02
`define UBD_DIV_HI_RST 8'h00
`define UBD_TICKS_PER_BIT 4'hF
`define UBD_HALF_BIT 4'h7
`define UBD_CAUSE_NONE 3'h0
`define UBD_CAUSE_HOLDING_EMPTY_FLAG 3'h1
`define UBD_CAUSE_RXD 3'h2
`define UBD_CAUSE_LINE 3'h3
`define UBD_RESP_OKAY 2'h0
`define UBD_RESP_SLVERR 2'h2
`endif

// file: ubd_pkg.sv
`default_nettype none
package ubd_pkg;
   typedef struct packed {
      logic dlab;
      logic brk;
      logic multi;
      logic even_parity_select;
      logic parity_enable;
      logic [2:0] fmt;
   } ubd_line_control_reg_t;
   typedef struct packed {
      logic [2:0] rsvd;
      logic tcie;
      logic miie;
      logic lsie;
      logic tie;
      logic rie;
   } ubd_ien_t;
   typedef enum logic [2:0] {S_IDLE, S_START, S_DATA, S_PAR, S_STOP} ubd_ser_t;
endpackage : ubd_pkg
`default_nettype wire

// file: ubd_uart.sv
// How it works
// R1: Divider is 16-bit down-counter decrementing each clock until it reaches one.
// R2: After count one, divider reloads divisor and pulses end-of-count tick.
// R3: End-of-count tick lasts exactly one clock per reload.
// R4: Reset sets divisor to two.
// R5: Writing either divisor byte loads counter and restarts count at once.
// R6: Software keeps divisor between two and all ones.
// R7: Divisor bytes reachable only with divisor-access bit set; bit resets low.
// R8: Low byte shares data address, high byte shares interrupt enable address.
// R9: Divisor reads return high byte above low byte.
// R10: Software sets access bit, writes divisor, then clears access bit.
// R11: Software picks divisor giving sixteen times bit rate.
// R12: Each transmitted bit lasts sixteen baud ticks.
// R13: Software configures with interrupts off, then enables all but transmit.
// R14: Enabling transmit interrupt with empty holding register raises it at once.
// R15: First holding register write after transmit interrupt drops it.
// R16: Software writes sixteen bytes with FIFO, one byte without.
// R17: Software sets parity enable and even parity select before address.
// R18: Multi-station mode clears even parity select after each transmitted byte.
// R19: Software waits for transmitter empty before setting parity select.
// R20: Software writes further bytes only while holding-empty flag is set.
// R21: Received address mark raises line status cause in identification register.
// R22: Receiver always enabled, continuously hunting start bit.
// R23: Software reads line status before each receive buffer read.
// R24: With interrupts off, software polls status registers.
//
// The AXI4-Lite interface to the registers was decided locally.
`include "ubd_map.svh"
`default_nettype none
module ubd_uart
   import ubd_pkg::*;
#(
   parameter int AW = 12
) (
   input wire logic CLK, // 25 MHz
   input wire logic RST, // Async, active high
   input wire logic CE, // Freezes all state when low
   input wire logic [AW-1:0] S_AXI_AWADDR, // Write address
   input wire logic S_AXI_AWVALID, // Write address valid
   output logic S_AXI_AWREADY, // Write address ready
   input wire logic [31:0] S_AXI_WDATA, // Write data
   input wire logic [3:0] S_AXI_WSTRB, // Byte enables
   input wire logic S_AXI_WVALID, // Write data valid
   output logic S_AXI_WREADY, // Write data ready
   output logic [1:0] S_AXI_BRESP, // Write response
   output logic S_AXI_BVALID, // Write response valid
   input wire logic S_AXI_BREADY, // Write response ready
   input wire logic [AW-1:0] S_AXI_ARADDR, // Read address
   input wire logic S_AXI_ARVALID, // Read address valid
   output logic S_AXI_ARREADY, // Read address ready
   output logic [31:0] S_AXI_RDATA, // Read data
   output logic [1:0] S_AXI_RRESP, // Read response
   output logic S_AXI_RVALID, // Read data valid
   input wire logic S_AXI_RREADY, // Read data ready
   input wire logic RXD, // Serial input
   output logic TXD, // Serial output, idle high
   output logic IRQ // Interrupt request, active high
);
   logic aw_hold, w_hold;
   logic [9:0] aw_idx, ar_idx;
   logic [7:0] w_byte;
   logic w_lane;
   logic do_wr, do_rd, wr_data, wr_lo, wr_hi, rd_data, rd_lsts, map_w, map_r;
   logic [7:0] div_lo, div_hi, transmit_holding_reg, receive_buffer_reg, sh_tx, sh_rx;
   logic [15:0] divisor, cnt;
   logic tick;
   ubd_line_control_reg_t line_control_reg;
   ubd_ien_t ien;
   ubd_ser_t tx_st, rx_st;
   logic [3:0] tx_tk, rx_tk;
   logic [2:0] tx_bit, rx_bit;
   logic thr_full, tx_par, tx_done, rx_par, dr, line_err, rx_done, rx_err;
   logic [2:0] cause;
   logic [7:0] rd_val;

   assign divisor = {div_hi, div_lo};
   assign do_wr = aw_hold && w_hold && !S_AXI_BVALID;
   assign do_rd = S_AXI_ARVALID && S_AXI_ARREADY;
   assign ar_idx = S_AXI_ARADDR[11:2];
   assign wr_data = do_wr && w_lane && aw_idx == `UBD_IDX_DATA;
   assign wr_lo = wr_data && line_control_reg.dlab; // R7 R8
   assign wr_hi = do_wr && w_lane && aw_idx == `UBD_IDX_IEN && line_control_reg.dlab; // R7 R8
   assign rd_data = do_rd && ar_idx == `UBD_IDX_DATA && !line_control_reg.dlab;
   assign rd_lsts = do_rd && ar_idx == `UBD_IDX_LSTS;
   assign map_w = aw_idx inside {`UBD_IDX_DATA, `UBD_IDX_IEN, `UBD_IDX_IID,
                                 `UBD_IDX_LINE_CONTROL_REG, `UBD_IDX_LSTS};
   assign map_r = ar_idx inside {`UBD_IDX_DATA, `UBD_IDX_IEN, `UBD_IDX_IID,
                                 `UBD_IDX_LINE_CONTROL_REG, `UBD_IDX_LSTS};

   // Interrupt cause priority: line status, receive data, holding empty
   always_comb begin
      if (line_err && ien.lsie) cause = `UBD_CAUSE_LINE; // R21
      else if (dr && ien.rie) cause = `UBD_CAUSE_RXD;
      else if (!thr_full && ien.tie) cause = `UBD_CAUSE_HOLDING_EMPTY_FLAG; // R14
      else cause = `UBD_CAUSE_NONE;
   end

   always_comb begin
      case (ar_idx)
         `UBD_IDX_DATA: rd_val = line_control_reg.dlab ? div_lo : receive_buffer_reg; // R9
         `UBD_IDX_IEN: rd_val = line_control_reg.dlab ? div_hi : ien; // R9
         `UBD_IDX_IID: rd_val = {4'h0, cause, cause == `UBD_CAUSE_NONE};
         `UBD_IDX_LINE_CONTROL_REG: rd_val = line_control_reg;
         `UBD_IDX_LSTS: rd_val = {1'b0, tx_st == S_IDLE && !thr_full, !thr_full,
                                  2'h0, line_err, 1'b0, dr};
         default: rd_val = 8'h00;
      endcase
   end

   // Write channel: address and data taken in either order
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         aw_hold <= 1'b0;
         w_hold <= 1'b0;
         aw_idx <= 10'h000;
         w_byte <= 8'h00;
         w_lane <= 1'b0;
         S_AXI_AWREADY <= 1'b1;
         S_AXI_WREADY <= 1'b1;
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP <= `UBD_RESP_OKAY;
      end else if (CE) begin
         if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_hold <= 1'b1;
            aw_idx <= S_AXI_AWADDR[11:2];
            S_AXI_AWREADY <= 1'b0;
         end
         if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_hold <= 1'b1;
            w_byte <= S_AXI_WDATA[7:0];
            w_lane <= S_AXI_WSTRB[0];
            S_AXI_WREADY <= 1'b0;
         end
         if (do_wr) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP <= map_w ? `UBD_RESP_OKAY : `UBD_RESP_SLVERR;
         end else if (S_AXI_BVALID && S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
            S_AXI_AWREADY <= 1'b1;
            S_AXI_WREADY <= 1'b1;
         end
      end
   end

   // Read channel: one cycle from address to data
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         S_AXI_ARREADY <= 1'b1;
         S_AXI_RVALID <= 1'b0;
         S_AXI_RDATA <= 32'h00000000;
         S_AXI_RRESP <= `UBD_RESP_OKAY;
      end else if (CE) begin
         if (do_rd) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b1;
            S_AXI_RDATA <= {24'h000000, rd_val};
            S_AXI_RRESP <= map_r ? `UBD_RESP_OKAY : `UBD_RESP_SLVERR;
         end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_ARREADY <= 1'b1;
         end
      end
   end

   // Control registers; software write of parity select beats the auto-clear
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         div_lo <= `UBD_DIV_LO_RST; // R4
         div_hi <= `UBD_DIV_HI_RST; // R4
         line_control_reg <= '0; // R7
         ien <= '0;
      end else if (CE) begin
         if (wr_lo) div_lo <= w_byte;
         if (wr_hi) div_hi <= w_byte;
         if (do_wr && w_lane && aw_idx == `UBD_IDX_IEN && !line_control_reg.dlab) ien <= w_byte;
         if (do_wr && w_lane && aw_idx == `UBD_IDX_LINE_CONTROL_REG) line_control_reg <= w_byte;
         else if (tx_done && line_control_reg.multi) line_control_reg.even_parity_select <= 1'b0; // R18
      end
   end

   // Baud divider
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         cnt <= `UBD_DIV_RST;
         tick <= 1'b0;
      end else if (CE) begin
         if (wr_lo || wr_hi) begin
            cnt <= {wr_hi ? w_byte : div_hi, wr_lo ? w_byte : div_lo}; // R5
            tick <= 1'b0;
         end else if (cnt == 16'h0001) begin
            cnt <= divisor; // R2
            tick <= 1'b1; // R2 R3
         end else begin
            cnt <= cnt - 16'h0001; // R1
            tick <= 1'b0; // R3
         end
      end
   end

   // Transmitter: start, eight data bits lsb first, optional parity, stop
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         tx_st <= S_IDLE;
         tx_tk <= 4'h0;
         tx_bit <= 3'h0;
         sh_tx <= 8'h00;
         transmit_holding_reg <= 8'h00;
         thr_full <= 1'b0;
         tx_par <= 1'b0;
         tx_done <= 1'b0;
         TXD <= 1'b1;
      end else if (CE) begin
         tx_done <= 1'b0;
         if (wr_data && !line_control_reg.dlab) begin
            transmit_holding_reg <= w_byte;
            thr_full <= 1'b1; // R15
         end
         case (tx_st)
            S_IDLE: begin
               TXD <= 1'b1;
               if (thr_full && tick) begin
                  sh_tx <= transmit_holding_reg;
                  tx_par <= line_control_reg.multi ? line_control_reg.even_parity_select : (line_control_reg.even_parity_select ? ^transmit_holding_reg : ~^transmit_holding_reg);
                  if (!(wr_data && !line_control_reg.dlab)) thr_full <= 1'b0;
                  tx_st <= S_START;
                  tx_tk <= 4'h0;
                  TXD <= 1'b0;
               end
            end
            default: begin
               if (tick) begin
                  tx_tk <= tx_tk + 4'h1;
                  if (tx_tk == `UBD_TICKS_PER_BIT) begin // R12
                     case (tx_st)
                        S_START: begin
                           tx_st <= S_DATA;
                           tx_bit <= 3'h0;
                           TXD <= sh_tx[0];
                        end
                        S_DATA: begin
                           tx_bit <= tx_bit + 3'h1;
                           if (tx_bit == 3'h7) begin
                              tx_st <= line_control_reg.parity_enable ? S_PAR : S_STOP;
                              TXD <= line_control_reg.parity_enable ? tx_par : 1'b1;
                           end else TXD <= sh_tx[tx_bit+3'h1];
                        end
                        S_PAR: begin
                           tx_st <= S_STOP;
                           TXD <= 1'b1;
                        end
                        default: begin
                           tx_st <= S_IDLE;
                           tx_done <= 1'b1;
                        end
                     endcase
                  end
               end
            end
         endcase
      end
   end

   // Receiver: always hunting; start checked at half bit, then bit centres
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         rx_st <= S_IDLE;
         rx_tk <= 4'h0;
         rx_bit <= 3'h0;
         sh_rx <= 8'h00;
         rx_par <= 1'b0;
         rx_done <= 1'b0;
         rx_err <= 1'b0;
      end else if (CE) begin
         rx_done <= 1'b0;
         case (rx_st)
            S_IDLE: begin
               rx_tk <= 4'h0;
               if (!RXD) rx_st <= S_START; // R22
            end
            default: begin
               if (tick) begin
                  rx_tk <= rx_tk + 4'h1;
                  if (rx_st == S_START && rx_tk == `UBD_HALF_BIT) begin
                     rx_tk <= 4'h0;
                     rx_bit <= 3'h0;
                     rx_st <= RXD ? S_IDLE : S_DATA;
                  end else if (rx_st != S_START && rx_tk == `UBD_TICKS_PER_BIT) begin
                     case (rx_st)
                        S_DATA: begin
                           sh_rx <= {RXD, sh_rx[7:1]};
                           rx_bit <= rx_bit + 3'h1;
                           if (rx_bit == 3'h7) rx_st <= line_control_reg.parity_enable ? S_PAR : S_STOP;
                        end
                        S_PAR: begin
                           rx_par <= RXD;
                           rx_st <= S_STOP;
                        end
                        default: begin
                           rx_done <= 1'b1;
                           rx_err <= !RXD || (line_control_reg.parity_enable && (line_control_reg.multi ? rx_par :
                                     rx_par != (line_control_reg.even_parity_select ? ^sh_rx : ~^sh_rx)));
                           rx_st <= S_IDLE;
                        end
                     endcase
                  end
               end
            end
         endcase
      end
   end

   // Status flags: a new event wins over a clearing read
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         receive_buffer_reg <= 8'h00;
         dr <= 1'b0;
         line_err <= 1'b0;
         IRQ <= 1'b0;
      end else if (CE) begin
         if (rx_done) begin
            receive_buffer_reg <= sh_rx;
            dr <= 1'b1;
         end else if (rd_data) dr <= 1'b0;
         if (rx_done && rx_err) line_err <= 1'b1; // R21
         else if (rd_lsts) line_err <= 1'b0;
         IRQ <= cause != `UBD_CAUSE_NONE; // R14 R15
      end
   end

   default clocking cb @(posedge CLK iff CE); endclocking
   default disable iff (RST);

   count_down_a: assert property (cnt > 16'h0001 && !wr_lo && !wr_hi
      |=> cnt == $past(cnt) - 16'h0001) else $error("divider did not decrement"); // R1
   reload_tick_a: assert property (cnt == 16'h0001 && !wr_lo && !wr_hi
      |=> tick && cnt == divisor) else $error("divider did not reload"); // R2
   tick_single_a: assert property (tick |=> !tick) else $error("tick longer than one"); // R3
   div_restart_a: assert property (wr_lo || wr_hi |=> cnt == divisor && !tick)
      else $error("divisor write did not restart"); // R5
   div_locked_a: assert property (!line_control_reg.dlab |=> $stable(divisor))
      else $error("divisor changed while locked"); // R7
   div_read_a: assert property (do_rd && line_control_reg.dlab && ar_idx == `UBD_IDX_IEN
      |=> S_AXI_RDATA[7:0] == div_hi) else $error("divisor high read wrong"); // R9
   bit_hold_a: assert property (tx_st != S_IDLE && tick && tx_tk != `UBD_TICKS_PER_BIT
      |=> $stable(TXD)) else $error("tx bit changed early"); // R12
   tie_raise_a: assert property (ien.tie && !thr_full |-> ##[1:2] IRQ)
      else $error("transmit interrupt not raised"); // R14
   thr_drop_a: assert property (wr_data && !line_control_reg.dlab && !line_err && !dr
      |=> ##1 !IRQ) else $error("holding write kept interrupt"); // R15
   eps_clear_a: assert property (tx_done && line_control_reg.multi && !do_wr |=> !line_control_reg.even_parity_select)
      else $error("parity select not cleared"); // R18
   addr_mark_a: assert property (rx_done && rx_err && ien.lsie |=> cause == `UBD_CAUSE_LINE)
      else $error("address mark cause missing"); // R21
   rx_hunt_a: assert property (rx_st == S_IDLE && !RXD |=> rx_st == S_START)
      else $error("receiver missed start"); // R22

   tx_frame_c: cover property (tx_done);
   rx_frame_c: cover property (rx_done && !rx_err);
   mark_rx_c: cover property (rx_done && rx_err && line_control_reg.multi);
   div_write_c: cover property (wr_hi);
endmodule : ubd_uart
`default_nettype wire

// file: ubd_station.sv
`default_nettype none
module ubd_station (
   input wire logic CLK, // Bench clock
   input wire logic TXD, // Line from the block
   output logic RXD // Line into the block, idle high
);
   timeunit 1ns;
   timeprecision 1ns;
   int p = 32;
   int nb = 10;
   logic [10:0] got[$];
   int low_run[$];
   initial RXD = 1'h1;
   // Samples every bit of a frame at its middle and times the leading low run
   always begin : hear
      logic [10:0] f;
      int lw;
      @(negedge TXD);
      f = '1;
      lw = 0;
      for (int c = 1; c <= p * nb - p / 2; c++) begin
         @(posedge CLK);
         if (TXD == 1'h0 && lw == c - 1) lw = c;
         if (c % p == p / 2) f[c / p] = TXD;
      end
      got.push_back(f);
      low_run.push_back(lw);
   end
   // Eleven bit times always; the last one is idle high when parity is off
   task automatic send(input logic [7:0] d, input int par);
      logic [10:0] fr;
      fr = (par < 0) ? {2'h3, d, 1'h0} : {1'h1, par[0], d, 1'h0};
      for (int k = 0; k < 11; k++) begin
         RXD <= fr[k];
         repeat (p) @(posedge CLK);
      end
   endtask : send
endmodule : ubd_station
`default_nettype wire

// file: tb_top.sv
`include "ubd_map.svh"
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic ce = 1'h1;
   logic [11:0] awaddr = '0;
   logic [11:0] araddr = '0;
   logic awvalid = 1'h0;
   logic wvalid = 1'h0;
   logic bready = 1'h0;
   logic arvalid = 1'h0;
   logic rready = 1'h0;
   logic [31:0] wdata = '0;
   logic [3:0] wstrb = 4'h1;
   logic awready, wready, bvalid, arready, rvalid, txd, irq;
   logic [1:0] bresp, rresp, rs;
   logic [31:0] rdata, v;
   logic [7:0] d;
   wire logic rxd;
   int n_fail = 0;
   int samples_checked = 0;
   int seed = 68;
   int div = 2;
   logic [10:0] exp_q[$];
   always #20 clk = ~clk;
   ubd_uart ubd_uart_i (.CLK(clk), .RST(rst), .CE(ce), .S_AXI_AWADDR(awaddr),
      .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
      .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
      .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
      .S_AXI_RREADY(rready), .RXD(rxd), .TXD(txd), .IRQ(irq));
   ubd_station ubd_station_i (.CLK(clk), .TXD(txd), .RXD(rxd));
   task automatic close_out();
      if (n_fail == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : close_out
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e) begin
         n_fail++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk
   task automatic wr(input logic [9:0] ix, input logic [7:0] b);
      logic done;
      done = 1'h0;
      @(posedge clk);
      awaddr <= {ix, 2'h0};
      wdata <= {24'h0, b};
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      while (!done) begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'h0;
         if (wvalid && wready) wvalid <= 1'h0;
         if (bvalid && bready) begin
            done = 1'h1;
            rs = bresp;
            bready <= 1'h0;
         end
      end
   endtask : wr
   task automatic rd(input logic [9:0] ix);
      @(posedge clk);
      araddr <= {ix, 2'h0};
      arvalid <= 1'h1;
      rready <= 1'h1;
      do begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'h0;
      end while (!(rvalid === 1'h1));
      v = rdata;
      rs = rresp;
      rready <= 1'h0;
   endtask : rd
   task automatic rdc(input logic [9:0] ix, input logic [31:0] e);
      rd(ix);
      chk(v, e);
   endtask : rdc
   task automatic lsts_wait(input int b);
      do rd(`UBD_IDX_LSTS); while (v[b] !== 1'h1);
   endtask : lsts_wait
   task automatic set_div(input logic [15:0] dv, input logic [7:0] lc);
      wr(`UBD_IDX_LINE_CONTROL_REG, 8'h80);
      wr(`UBD_IDX_DATA, dv[7:0]);
      wr(`UBD_IDX_IEN, dv[15:8]);
      wr(`UBD_IDX_LINE_CONTROL_REG, lc);
      div = int'(dv);
      ubd_station_i.p = 16 * div;
   endtask : set_div
   // Model side: each byte handed to the holding register becomes one expected frame
   task automatic send_byte(input logic [7:0] b, input int par);
      lsts_wait(5);
      wr(`UBD_IDX_DATA, b);
      exp_q.push_back((par < 0) ? {2'h3, b, 1'h0} : {1'h1, par[0], b, 1'h0});
   endtask : send_byte
   task automatic tx_check();
      logic [10:0] e;
      int w;
      while (ubd_station_i.got.size() == 0) @(posedge clk);
      e = exp_q.pop_front();
      w = ubd_station_i.low_run.pop_front();
      chk({21'h0, ubd_station_i.got.pop_front()}, {21'h0, e});
      if (e[1]) chk(w, 16 * div);
   endtask : tx_check
   initial begin
      repeat (80000) @(posedge clk);
      n_fail++;
      close_out();
   end
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'h0;
      rdc(`UBD_IDX_IID, 32'h1);
      rdc(`UBD_IDX_LINE_CONTROL_REG, 32'h0);
      rdc(10'h0C4, 32'h0);
      chk({30'h0, rs}, 32'h2);
      wr(10'h0C4, 8'h00);
      chk({30'h0, rs}, 32'h2);
      wr(`UBD_IDX_LINE_CONTROL_REG, 8'h80);
      chk({30'h0, rs}, 32'h0);
      rdc(`UBD_IDX_DATA, 32'h2);
      rdc(`UBD_IDX_IEN, 32'h0);
      wr(`UBD_IDX_IEN, 8'h01);
      rdc(`UBD_IDX_DATA, 32'h2);
      rdc(`UBD_IDX_IEN, 32'h1);
      wr(`UBD_IDX_LINE_CONTROL_REG, 8'h00);
      rdc(`UBD_IDX_IEN, 32'h0);
      wr(`UBD_IDX_IEN, 8'h04);
      set_div(16'h0003, 8'h00);
      rdc(`UBD_IDX_IEN, 32'h4);
      for (int i = 0; i < 4; i++) begin
         v = $random(seed);
         send_byte(i == 0 ? 8'h5B : v[7:0], -1);
      end
      for (int i = 0; i < 4; i++) tx_check();
      lsts_wait(6);
      wr(`UBD_IDX_LINE_CONTROL_REG, 8'h38);
      ubd_station_i.nb = 11;
      send_byte(8'hA5, 1);
      send_byte(8'h3C, 0);
      tx_check();
      tx_check();
      rdc(`UBD_IDX_LINE_CONTROL_REG, 32'h28);
      lsts_wait(6);
      ubd_station_i.nb = 10;
      set_div(16'h0040, 8'h00);
      wr(`UBD_IDX_IEN, 8'h02);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h1);
      rdc(`UBD_IDX_IID, 32'h2);
      send_byte(8'hC3, -1);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      tx_check();
      wr(`UBD_IDX_IEN, 8'h04);
      set_div(16'h0003, 8'h28);
      ubd_station_i.send(8'h47, 1);
      rdc(`UBD_IDX_IID, 32'h6);
      chk({31'h0, irq}, 32'h1);
      rdc(`UBD_IDX_LSTS, 32'h65);
      rdc(`UBD_IDX_DATA, 32'h47);
      rdc(`UBD_IDX_LSTS, 32'h60);
      wr(`UBD_IDX_LINE_CONTROL_REG, 8'h00);
      for (int i = 0; i < 3; i++) begin
         v = $random(seed);
         d = v[7:0];
         ubd_station_i.send(d, -1);
         rdc(`UBD_IDX_LSTS, 32'h61);
         rdc(`UBD_IDX_DATA, {24'h0, d});
      end
      close_out();
   end
endmodule : tb_top
`default_nettype wire
